// File: design/uei_regs.vh
// uei_regs.vh: register indices, field positions, reset values and timing
// for the usb event and interrupt logic; definitions only
`ifndef UEI_REGS_VH
`define UEI_REGS_VH

// register indices, byte address is four times the index
`define UEI_IDX_BUS_EN       8'hE4
`define UEI_IDX_TX_EN        8'hE5
`define UEI_IDX_RX_EN        8'hE6
`define UEI_IDX_NAK_EN       8'hE7
`define UEI_IDX_FLAGS        8'hE8
`define UEI_IDX_TX_FLAGS     8'hE9
`define UEI_IDX_RX_FLAGS     8'hEA
`define UEI_IDX_NAK_FLAGS    8'hEB

// reset values, bus event and endpoint registers
`define UEI_RST_BUS          4'h0
`define UEI_RST_EP           5'h00

// bus event bit positions, shared by enable and flag registers
`define UEI_BIT_RESET        3
`define UEI_BIT_IDLE         2
`define UEI_BIT_EOP          1
`define UEI_BIT_WAKE         0

// summary bit positions in the flag register
`define UEI_BIT_SUM_BUS      7
`define UEI_BIT_SUM_TX       6
`define UEI_BIT_SUM_RX       5
`define UEI_BIT_SUM_NAK      4

// endpoints
`define UEI_NUM_EP           5
`define UEI_EP_MAX           3'h4

// timing
`define UEI_CLK_MHZ          40
`define UEI_RESET_TIME_US    10000
`define UEI_IDLE_TIME_US     3000
// cycle counts at 40 MHz, sized to the counter width
`define UEI_RESET_CYCLES     19'd400000
`define UEI_IDLE_CYCLES      19'd120000
`define UEI_CNT_W            19

`endif

// File: design/uei_irq.v
// uei_irq.v: usb bus event detection, interrupt enable and flag registers
// assumes apb master on clk, line and sie inputs synchronous to clk
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "uei_regs.vh"

module uei_irq #(
    parameter [`UEI_CNT_W-1:0] RESET_CYCLES = `UEI_RESET_CYCLES,
    parameter [`UEI_CNT_W-1:0] IDLE_CYCLES  = `UEI_IDLE_CYCLES
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        line_dp,
    input  wire        line_dm,
    input  wire [4:0]  ep_tx_done,
    input  wire [4:0]  ep_rx_filled,
    input  wire [4:0]  ep_tx_empty,
    input  wire        in_token,
    input  wire [2:0]  in_token_ep,
    output reg         nak_send,
    output wire        sie_clk_en,
    output wire        usb_irq
);

    localparam [2:0] ST_LINE = 3'b001;
    localparam [2:0] ST_SE0  = 3'b010;
    localparam [2:0] ST_RST  = 3'b100;
    localparam [1:0] LINE_IDLE = 2'b10;

    // write-zero clears, hardware set wins
    function [7:0] flag_next;
        input [7:0] cur;
        input       wr;
        input [7:0] wdata;
        input [7:0] set;
        begin
            flag_next = (wr ? (cur & wdata) : cur) | set;
        end
    endfunction

    // endpoint number to one-hot, zero when out of range
    function [4:0] ep_onehot;
        input [2:0] ep;
        begin
            ep_onehot = 5'h00;
            if (ep <= `UEI_EP_MAX) begin
                ep_onehot[ep] = 1'b1;
            end
        end
    endfunction

    // register index match against the apb word address
    function idx_hit;
        input [11:0] addr;
        input [7:0]  idx;
        begin
            idx_hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
        end
    endfunction

    reg  [3:0]            bus_en;
    reg  [4:0]            tx_en;
    reg  [4:0]            rx_en;
    reg  [4:0]            nak_en;
    reg  [3:0]            bus_flags;
    reg  [4:0]            tx_flags;
    reg  [4:0]            rx_flags;
    reg  [4:0]            nak_flags;
    reg  [2:0]            line_state;
    reg  [2:0]            next_line_state;
    reg  [`UEI_CNT_W-1:0] se0_cnt;
    reg  [`UEI_CNT_W-1:0] idle_cnt;
    reg                   idle_done;
    reg  [1:0]            line_prev;

    wire                  wr_en;
    wire                  rd_en;
    wire                  hit_bus_en;
    wire                  hit_tx_en;
    wire                  hit_rx_en;
    wire                  hit_nak_en;
    wire                  hit_flags;
    wire                  hit_tx_flags;
    wire                  hit_rx_flags;
    wire                  hit_nak_flags;
    wire                  mapped;
    wire                  se0;
    wire                  activity;
    wire                  rst_evt;
    wire                  eop_evt;
    wire                  idle_evt;
    wire                  wake_evt;
    wire [4:0]            nak_evt;
    wire [3:0]            bus_set;
    wire [7:0]            bus_nxt;
    wire [7:0]            tx_nxt;
    wire [7:0]            rx_nxt;
    wire [7:0]            nak_nxt;
    wire [7:0]            flags_view;
    wire                  bus_event_summary;
    wire                  tx_empty_summary;
    wire                  rx_full_summary;
    wire                  refused_summary;
    wire                  bus_pend;
    wire                  tx_pend;
    wire                  rx_pend;
    wire                  nak_pend;

    // apb slave, zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;

    assign hit_bus_en    = idx_hit(paddr, `UEI_IDX_BUS_EN);
    assign hit_tx_en     = idx_hit(paddr, `UEI_IDX_TX_EN);
    assign hit_rx_en     = idx_hit(paddr, `UEI_IDX_RX_EN);
    assign hit_nak_en    = idx_hit(paddr, `UEI_IDX_NAK_EN);
    assign hit_flags     = idx_hit(paddr, `UEI_IDX_FLAGS);
    assign hit_tx_flags  = idx_hit(paddr, `UEI_IDX_TX_FLAGS);
    assign hit_rx_flags  = idx_hit(paddr, `UEI_IDX_RX_FLAGS);
    assign hit_nak_flags = idx_hit(paddr, `UEI_IDX_NAK_FLAGS);
    assign mapped = hit_bus_en | hit_tx_en | hit_rx_en | hit_nak_en |
                    hit_flags | hit_tx_flags | hit_rx_flags | hit_nak_flags;
    assign pslverr = psel & penable & ~mapped;

    // line monitor
    assign se0      = ~line_dp & ~line_dm;
    assign activity = (line_prev != {line_dp, line_dm});

    always @* begin
        next_line_state = line_state;
        case (line_state)
            ST_LINE: begin
                if (se0) begin
                    next_line_state = ST_SE0;
                end
            end
            ST_SE0: begin
                if (!se0) begin
                    next_line_state = ST_LINE;
                end else if (se0_cnt >= RESET_CYCLES - 1'b1) begin
                    next_line_state = ST_RST;
                end
            end
            ST_RST: begin
                if (!se0) begin
                    next_line_state = ST_LINE;
                end
            end
            default: begin
                next_line_state = ST_LINE;
            end
        endcase
    end

    // one event per long se0 episode; cpu keeps running, engine clock already stopped by the idle flag since IDLE_CYCLES < RESET_CYCLES
    assign rst_evt  = (line_state == ST_SE0) && (next_line_state == ST_RST);
    // short se0 returning to a driven line ends a packet
    assign eop_evt  = (line_state == ST_SE0) && !se0;
    assign idle_evt = !idle_done && !activity && (idle_cnt >= IDLE_CYCLES - 1'b1);
    assign wake_evt = activity && bus_flags[`UEI_BIT_IDLE];

    // line state and last line sample, idle j after reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_state <= ST_LINE;
            line_prev  <= LINE_IDLE;
        end else begin
            line_state <= next_line_state;
            line_prev  <= {line_dp, line_dm};
        end
    end

    // se0 duration counter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            se0_cnt <= {`UEI_CNT_W{1'b0}};
        end else if (line_state == ST_SE0 && se0) begin
            se0_cnt <= se0_cnt + 1'b1;
        end else begin
            se0_cnt <= {`UEI_CNT_W{1'b0}};
        end
    end

    // bus idle counter, one suspend event per quiet spell
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt  <= {`UEI_CNT_W{1'b0}};
            idle_done <= 1'b0;
        end else if (activity) begin
            idle_cnt  <= {`UEI_CNT_W{1'b0}};
            idle_done <= 1'b0;
        end else if (idle_evt) begin
            idle_done <= 1'b1;
        end else if (!idle_done) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // nak answer for in token on an empty endpoint fifo
    assign nak_evt = in_token ? (ep_onehot(in_token_ep) & ep_tx_empty) : 5'h00;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nak_send <= 1'b0;
        end else begin
            nak_send <= |nak_evt;
        end
    end

    // flag updates
    assign bus_set = {rst_evt, idle_evt, eop_evt, wake_evt};
    assign bus_nxt = flag_next({4'h0, bus_flags}, wr_en & hit_flags,
                               pwdata[7:0], {4'h0, bus_set});
    assign tx_nxt  = flag_next({3'h0, tx_flags}, wr_en & hit_tx_flags,
                               pwdata[7:0], {3'h0, ep_tx_done});
    assign rx_nxt  = flag_next({3'h0, rx_flags}, wr_en & hit_rx_flags,
                               pwdata[7:0], {3'h0, ep_rx_filled});
    assign nak_nxt = flag_next({3'h0, nak_flags}, wr_en & hit_nak_flags,
                               pwdata[7:0], {3'h0, nak_evt});

    // bus event enables
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_en <= `UEI_RST_BUS;
        end else if (wr_en && hit_bus_en) begin
            bus_en <= pwdata[3:0];
        end
    end

    // in fifo enables
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_en <= `UEI_RST_EP;
        end else if (wr_en && hit_tx_en) begin
            tx_en <= pwdata[4:0];
        end
    end

    // out fifo enables
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_en <= `UEI_RST_EP;
        end else if (wr_en && hit_rx_en) begin
            rx_en <= pwdata[4:0];
        end
    end

    // nak enables
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nak_en <= `UEI_RST_EP;
        end else if (wr_en && hit_nak_en) begin
            nak_en <= pwdata[4:0];
        end
    end

    // bus event flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_flags <= `UEI_RST_BUS;
        end else begin
            bus_flags <= bus_nxt[3:0];
        end
    end

    // in fifo flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_flags <= `UEI_RST_EP;
        end else begin
            tx_flags <= tx_nxt[4:0];
        end
    end

    // out fifo flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_flags <= `UEI_RST_EP;
        end else begin
            rx_flags <= rx_nxt[4:0];
        end
    end

    // nak flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nak_flags <= `UEI_RST_EP;
        end else begin
            nak_flags <= nak_nxt[4:0];
        end
    end

    // engine clock off while suspend flag stands
    assign sie_clk_en = ~bus_flags[`UEI_BIT_IDLE];

    // summaries and flag register view
    assign bus_event_summary = |bus_flags;
    assign tx_empty_summary  = |tx_flags;
    assign rx_full_summary   = |rx_flags;
    assign refused_summary   = |nak_flags;
    assign flags_view = {bus_event_summary, tx_empty_summary, rx_full_summary,
                         refused_summary, bus_flags};

    // single shared request line
    assign bus_pend = |(bus_flags & bus_en);
    assign tx_pend  = |(tx_flags & tx_en);
    assign rx_pend  = |(rx_flags & rx_en);
    assign nak_pend = |(nak_flags & nak_en);
    assign usb_irq  = bus_pend | tx_pend | rx_pend | nak_pend;

    // read data captured in setup, stable through access
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= 32'h00000000;
            if (hit_bus_en) begin
                prdata[3:0] <= bus_en;
            end
            if (hit_tx_en) begin
                prdata[4:0] <= tx_en;
            end
            if (hit_rx_en) begin
                prdata[4:0] <= rx_en;
            end
            if (hit_nak_en) begin
                prdata[4:0] <= nak_en;
            end
            if (hit_flags) begin
                prdata[7:0] <= flags_view;
            end
            if (hit_tx_flags) begin
                prdata[4:0] <= tx_flags;
            end
            if (hit_rx_flags) begin
                prdata[4:0] <= rx_flags;
            end
            if (hit_nak_flags) begin
                prdata[4:0] <= nak_flags;
            end
        end
    end

endmodule
`default_nettype wire

// File: tb/uei_irq_props.sv
// uei_irq_props.sv: port checker for uei_irq
// bound from the bench top; sees the design ports only
`timescale 1ns/100ps
`default_nettype none
module uei_irq_props #(
    parameter int RESET_CYCLES = 20,
    parameter int IDLE_CYCLES  = 10
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        line_dp,
    input wire logic        line_dm,
    input wire logic [4:0]  ep_tx_empty,
    input wire logic        in_token,
    input wire logic [2:0]  in_token_ep,
    input wire logic        nak_send,
    input wire logic        sie_clk_en,
    input wire logic        usb_irq
);
    logic [7:0] en [0:3];
    logic [7:0] sc;
    logic [1:0] ln_q;
    logic [1:0] idx;
    logic       mapped;
    logic       en_reg;
    logic       hit;
    logic       clr_idle;
    assign idx = paddr[3:2];
    assign mapped = paddr[1:0] == 2'h0 && paddr >= 12'h390 && paddr <= 12'h3AC;
    assign en_reg = psel && penable && paddr[11:4] == 8'h39 && paddr[1:0] == 2'h0;
    assign hit = in_token && in_token_ep <= 3'h4 && ep_tx_empty[in_token_ep];
    assign clr_idle = psel && penable && pwrite && paddr == 12'h3A0 && !pwdata[2];
    // shadow of the enables and a count of unchanged line samples
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en <= '{default: 8'h00};
            sc <= 8'h00;
            ln_q <= 2'h0;
        end else begin
            ln_q <= {line_dp, line_dm};
            sc <= (ln_q != {line_dp, line_dm}) ? 8'h00 : (sc == 8'hFF) ? sc : sc + 8'h01;
            if (en_reg && pwrite)
                en[idx] <= pwdata[7:0] & ((idx == 2'h0) ? 8'h0F : 8'h1F);
        end
    end
    nak_hit_a: assert property (@(posedge clk) disable iff (!rst_n) hit |=> nak_send)
        else $error("no nak after in token on empty endpoint");
    nak_cause_a: assert property (@(posedge clk) disable iff (!rst_n) nak_send |-> $past(hit))
        else $error("nak without cause");
    bad_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && penable && !mapped |-> pslverr) else $error("unmapped access not refused");
    setup_resp_a: assert property (@(posedge clk) disable iff (!rst_n)
        psel && !penable |=> pslverr == !mapped) else $error("wrong slave error");
    bus_en_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        en_reg && !pwrite && idx == 2'h0 |-> prdata == {24'h0, en[0]})
        else $error("bus enable read wrong");
    ep_en_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        en_reg && !pwrite && idx != 2'h0 |-> prdata == {24'h0, en[idx]})
        else $error("endpoint enable read wrong");
    irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        en[0] == 8'h0 && en[1] == 8'h0 && en[2] == 8'h0 && en[3] == 8'h0 |-> !usb_irq)
        else $error("irq with all enables clear");
    clk_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sie_clk_en) |-> sc >= IDLE_CYCLES - 3) else $error("engine clock stop early");
    clk_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sie_clk_en) |-> $past(clr_idle)) else $error("engine clock restart uncaused");
endmodule
`default_nettype wire

// File: tb/uei_host.sv
// uei_host.sv: usb host line model
// mode from the bench: 0 idle j, 1 se0, 2 j/k traffic
`timescale 1ns/100ps
`default_nettype none
module uei_host (
    input  wire logic       clk,
    input  wire logic [1:0] mode,
    output var  logic       dp,
    output var  logic       dm
);
    always @(posedge clk) begin
        case (mode)
            2'h0: {dp, dm} <= 2'h2;
            2'h1: {dp, dm} <= 2'h0;
            default: {dp, dm} <= (dp === 1'b1) ? 2'h1 : 2'h2;
        endcase
    end
endmodule
`default_nettype wire

// File: tb/uei_irq_tb.sv
// uei_irq_tb.sv: self-checking bench for uei_irq
// apb master, endpoint strobes and host model on one 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module uei_irq_tb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        in_token, nak_send, sie_clk_en, usb_irq, dp, dm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic [4:0]  ep_tx_done, ep_rx_filled, ep_tx_empty;
    logic [2:0]  in_token_ep;
    logic [1:0]  host_mode;
    int          error_cnt, checked, cyc, seed, k, g;
    uei_irq #(.RESET_CYCLES(19'd20), .IDLE_CYCLES(19'd10)) dut_u (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_dp(dp), .line_dm(dm), .ep_tx_done(ep_tx_done),
        .ep_rx_filled(ep_rx_filled), .ep_tx_empty(ep_tx_empty), .in_token(in_token),
        .in_token_ep(in_token_ep), .nak_send(nak_send), .sie_clk_en(sie_clk_en),
        .usb_irq(usb_irq));
    uei_host host_u (.clk(clk), .mode(host_mode), .dp(dp), .dm(dm));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task stop_test;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test;
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task hold(input logic [1:0] m, input int n);
        host_mode <= m;
        repeat (n) @(posedge clk);
    endtask
    task fire(input int gs, input int ks);
        @(posedge clk);
        ep_tx_done <= (gs == 0) ? 5'(1 << ks) : 5'h00;
        ep_rx_filled <= (gs == 1) ? 5'(1 << ks) : 5'h00;
        in_token <= (gs == 2); in_token_ep <= 3'(ks);
        @(posedge clk);
        ep_tx_done <= 5'h00; ep_rx_filled <= 5'h00; in_token <= 1'b0;
        @(posedge clk);
    endtask
    function logic [31:0] en_exp(input int i, input logic [31:0] d);
        return d & ((i == 0) ? 32'h0F : 32'h1F);
    endfunction
    initial begin
        seed = 48813; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; ep_tx_done = 5'h00; ep_rx_filled = 5'h00;
        ep_tx_empty = 5'h1F; in_token = 1'b0; in_token_ep = 3'h0; host_mode = 2'h2;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (k = 0; k < 8; k++) rdchk(12'h390 + 12'(4 * k), 32'h0);
        for (k = 0; k < 4; k++) begin
            rnd = $random(seed);
            apb(1'b1, 12'h390 + 12'(4 * k), rnd);
            rdchk(12'h390 + 12'(4 * k), en_exp(k, rnd));
        end
        apb(1'b0, 12'h3B0, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, 12'h3A0, 32'hFF);
        rdchk(12'h3A0, 32'h0);
        for (g = 0; g < 3; g++) begin
            k = {$random(seed)} % 5;
            ep_tx_empty <= 5'($random(seed)) | 5'(1 << k);
            apb(1'b1, 12'h394 + 12'(4 * g), 32'h1 << k);
            fire(g, k);
            `CHK(usb_irq, 1'b1)
            rdchk(12'h3A4 + 12'(4 * g), 32'h1 << k);
            rdchk(12'h3A0, 32'h40 >> g);
            apb(1'b1, 12'h3A4 + 12'(4 * g), 32'hFF);
            rdchk(12'h3A4 + 12'(4 * g), 32'h1 << k);
            apb(1'b1, 12'h3A4 + 12'(4 * g), 32'h0);
            rdchk(12'h3A4 + 12'(4 * g), 32'h0);
            `CHK(usb_irq, 1'b0)
        end
        for (k = 0; k < 4; k++) apb(1'b1, 12'h390 + 12'(4 * k), 32'h0);
        hold(2'h1, 3);
        hold(2'h2, 6);
        rdchk(12'h3A0, 32'h82);
        `CHK(usb_irq, 1'b0)
        apb(1'b1, 12'h390, 32'h2);
        @(posedge clk);
        `CHK(usb_irq, 1'b1)
        apb(1'b1, 12'h3A0, 32'h0);
        hold(2'h0, 20);
        `CHK(sie_clk_en, 1'b0)
        rdchk(12'h3A0, 32'h84);
        hold(2'h2, 4);
        rdchk(12'h3A0, 32'h85);
        apb(1'b1, 12'h3A0, 32'hFB);
        @(posedge clk);
        `CHK(sie_clk_en, 1'b1)
        rdchk(12'h3A0, 32'h81);
        apb(1'b1, 12'h3A0, 32'h0);
        hold(2'h1, 30);
        hold(2'h2, 4);
        apb(1'b0, 12'h3A0, 32'h0);
        `CHK(rd & 32'h08, 32'h08)
        rdchk(12'h390, 32'h2);
        apb(1'b1, 12'h3A0, 32'h0);
        @(posedge clk);
        `CHK(sie_clk_en, 1'b1)
        stop_test;
    end
endmodule
bind uei_irq uei_irq_props #(.RESET_CYCLES(20), .IDLE_CYCLES(10)) props_u (
    .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .line_dp(line_dp), .line_dm(line_dm), .ep_tx_empty(ep_tx_empty), .in_token(in_token),
    .in_token_ep(in_token_ep), .nak_send(nak_send), .sie_clk_en(sie_clk_en),
    .usb_irq(usb_irq));
`default_nettype wire
